// File: ppi_pkg.sv
/*
  Constants, register map and types for the downstream port power and
  indicator block of a four-port hub.
  Assumes a 250 MHz core clock and an AHB-Lite register bus with 32-bit data.
*/
package ppi_pkg;
  localparam int NPORTS = 4;
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLINK_HALF_MS = 375;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OC_TIME_OFS = 8'h04;
  localparam logic [7:0] POWER_OFS = 8'h08;
  localparam logic [7:0] ENABLE_OFS = 8'h0C;
  localparam logic [7:0] RESET_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] HUB_CHAR_OFS = 8'h18;
  localparam logic [7:0] IND_OFS = 8'h1C;

  // Control bit positions
  localparam int CTRL_GANG_BIT = 0;
  localparam int CTRL_IND_DIS_BIT = 1;
  localparam int CTRL_NO_SWITCH_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Over-current time fields
  localparam int OC_EN_LSB = 0;
  localparam int OC_DIS_LSB = 4;
  localparam logic [3:0] OC_TIME_RESET = 4'h8;

  // Status fields
  localparam int ST_OC_LSB = 0;
  localparam int ST_BAB_LSB = 4;
  localparam int HUB_CHAR_IND_BIT = 7;

  // Indicator control: per port a nibble, bit 3 manual, bits 2:0 selector
  localparam int IND_MANUAL_BIT = 3;
  localparam logic [15:0] IND_RESET = 16'h0000;

  typedef enum logic [2:0] {
    PPI_SEL_OFF = 3'h0,
    PPI_SEL_AMBER = 3'h1,
    PPI_SEL_GREEN = 3'h2,
    PPI_SEL_BLINK_GREEN = 3'h3,
    PPI_SEL_BLINK_AMBER = 3'h4,
    PPI_SEL_BLINK_RSVD = 3'h5
  } ppi_sel_t;

  typedef enum logic [3:0] {
    PPI_ST_POWERED_OFF = 4'h0,
    PPI_ST_DISCONNECTED = 4'h1,
    PPI_ST_DISABLED = 4'h2,
    PPI_ST_NOT_CONFIGURED = 4'h3,
    PPI_ST_RESETTING = 4'h4,
    PPI_ST_TESTING = 4'h5,
    PPI_ST_ENABLED = 4'h6,
    PPI_ST_TRANSMIT = 4'h7,
    PPI_ST_TRANSMITR = 4'h8,
    PPI_ST_SUSPENDED = 4'h9,
    PPI_ST_RESUMING = 4'hA,
    PPI_ST_SEND_EOR = 4'hB,
    PPI_ST_RESTART = 4'hC
  } ppi_port_state_t;
endpackage

// File: ppi_port_power_indicator_ctrl.sv
/*
  Downstream port power switching, timed over-current qualification,
  two-colour port indicators and the upstream speed and event block.
  Assumes the hub controller supplies port states, babble and disconnect
  events on the core clock; switch flags arrive asynchronously on pins.
*/
`timescale 1ns/1ps
`default_nettype none
module ppi_port_power_indicator_ctrl #(
  parameter int MS_CYCLES = ppi_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Hub controller side
  input wire logic hub_cfg_high_speed,
  input wire logic repeater_upstream_active,
  input wire logic [3:0] ds_babble,
  input wire logic [3:0] ds_disconnect,
  input wire logic [15:0] port_state,
  output logic up_high_speed,
  output logic up_event_block,
  output logic [3:0] port_disconnect,
  output logic [7:0] hub_characteristics,
  // External power switch
  output logic [3:0] port_power_enable_n,
  input wire logic [3:0] port_overcurrent_flag_n,
  // Indicator LEDs
  output logic [3:0] port_led_green,
  output logic [3:0] port_led_amber
);

  // Automatic colour, returned as {green, amber}
  function automatic logic [1:0] auto_colour(input logic [3:0] st, input logic oc,
                                             input logic no_switch);
    logic [1:0] c;
    c = 2'h0;
    case (st)
      ppi_pkg::PPI_ST_ENABLED, ppi_pkg::PPI_ST_TRANSMIT, ppi_pkg::PPI_ST_TRANSMITR: begin
        c = 2'h2;
      end
      ppi_pkg::PPI_ST_POWERED_OFF: begin
        c = {1'b0, oc & ~no_switch};
      end
      ppi_pkg::PPI_ST_DISCONNECTED, ppi_pkg::PPI_ST_DISABLED,
      ppi_pkg::PPI_ST_NOT_CONFIGURED, ppi_pkg::PPI_ST_RESETTING,
      ppi_pkg::PPI_ST_TESTING: begin
        c = {1'b0, oc & no_switch};
      end
      ppi_pkg::PPI_ST_SUSPENDED, ppi_pkg::PPI_ST_RESUMING,
      ppi_pkg::PPI_ST_SEND_EOR, ppi_pkg::PPI_ST_RESTART: begin
        c = 2'h0; // Suspend group shows off
      end
      default: begin
        c = 2'h0; // Unknown codes stay dark
      end
    endcase
    return c;
  endfunction

  // Manual colour, returned as {green, amber}
  function automatic logic [1:0] manual_colour(input logic [2:0] sel, input logic phase);
    logic [1:0] c;
    c = 2'h0;
    case (sel)
      ppi_pkg::PPI_SEL_AMBER: begin
        c = 2'h1;
      end
      ppi_pkg::PPI_SEL_GREEN: begin
        c = 2'h2;
      end
      ppi_pkg::PPI_SEL_BLINK_GREEN: begin
        c = {phase, 1'b0};
      end
      ppi_pkg::PPI_SEL_BLINK_AMBER: begin
        c = {1'b0, phase};
      end
      // Reserved green/amber blink is shown as off rather than guessed at
      default: begin
        c = 2'h0;
      end
    endcase
    return c;
  endfunction

  // Registers
  logic [2:0] ctrl;
  logic [7:0] oc_time;
  logic [3:0] power_req;
  logic [3:0] port_en;
  logic [3:0] oc_flag;
  logic [3:0] bab_flag;
  logic [15:0] ind_ctrl;
  logic [3:0] ind_override;

  // Bus data phase
  logic wr_pend;
  logic [7:0] wr_addr;

  // Time base
  logic [17:0] ms_cnt;
  logic ms_tick;
  logic [8:0] blink_cnt;
  logic blink_phase;

  // Over-current synchroniser and timers
  logic [3:0] oc_meta;
  logic [3:0] oc_sync;
  logic [4:0] oc_cnt [4];
  logic [3:0] oc_qual;

  // Address phase decode
  wire addr_phase = hsel & htrans[1] & hready;
  wire [7:0] a_ofs = haddr[7:0];
  wire a_hit = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);

  // Data phase write strobes
  wire wr_ctrl = wr_pend & (wr_addr == ppi_pkg::CTRL_OFS);
  wire wr_oct = wr_pend & (wr_addr == ppi_pkg::OC_TIME_OFS);
  wire wr_pwr = wr_pend & (wr_addr == ppi_pkg::POWER_OFS);
  wire wr_en = wr_pend & (wr_addr == ppi_pkg::ENABLE_OFS);
  wire wr_rst = wr_pend & (wr_addr == ppi_pkg::RESET_OFS);
  wire wr_stat = wr_pend & (wr_addr == ppi_pkg::STATUS_OFS);
  wire wr_ind = wr_pend & (wr_addr == ppi_pkg::IND_OFS);

  wire gang = ctrl[ppi_pkg::CTRL_GANG_BIT];
  wire ind_dis = ctrl[ppi_pkg::CTRL_IND_DIS_BIT];
  wire no_switch = ctrl[ppi_pkg::CTRL_NO_SWITCH_BIT];

  // Babble only counts on an enabled port
  wire [3:0] bab_hit = ds_babble & port_en;

  wire [3:0] reset_req = wr_rst ? hwdata[3:0] : 4'h0;
  wire [3:0] en_clear = wr_en ? hwdata[3:0] : 4'h0;
  wire [3:0] oc_any = gang ? {4{|oc_qual}} : oc_qual;
  // Write-one-to-clear masks for the sticky status bits
  wire [3:0] oc_clear = wr_stat ? hwdata[3:0] : 4'h0;
  wire [3:0] bab_clear = wr_stat ? hwdata[7:4] : 4'h0;
  // A write to the indicator word with a port's manual bit set is a host override
  wire [3:0] ind_manual_wr = wr_ind ? {hwdata[15], hwdata[11], hwdata[7], hwdata[3]} : 4'h0;

  // Power request: hardware drop on fault wins over a same-cycle write
  wire [3:0] next_power_req = (wr_pwr ? hwdata[3:0] : power_req) & ~oc_any;
  // Ganged mode: any request powers all ports; a fault on any port has cleared them all
  wire [3:0] power_on = gang ? {4{|next_power_req}} : next_power_req;
  wire [3:0] next_port_en = (port_en | reset_req) & ~en_clear & ~bab_hit & ~oc_qual;
  // Sticky status, set wins over write-one-to-clear
  wire [3:0] next_oc_flag = (oc_flag & ~oc_clear) | oc_qual;
  wire [3:0] next_bab_flag = (bab_flag & ~bab_clear) | bab_hit;

  // Read mux for the address phase
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (a_ofs)
      ppi_pkg::CTRL_OFS: rd_mux = {29'h0, ctrl};
      ppi_pkg::OC_TIME_OFS: rd_mux = {24'h0, oc_time};
      ppi_pkg::POWER_OFS: rd_mux = {28'h0, power_req};
      ppi_pkg::ENABLE_OFS: rd_mux = {28'h0, port_en};
      ppi_pkg::STATUS_OFS: rd_mux = {20'h0, ~port_power_enable_n, bab_flag, oc_flag};
      ppi_pkg::HUB_CHAR_OFS: rd_mux = {24'h0, hub_characteristics};
      ppi_pkg::IND_OFS: rd_mux = {16'h0, ind_ctrl};
      default: rd_mux = 32'h00000000;
    endcase
    if (!a_hit) begin
      rd_mux = 32'h00000000;
    end
  end

  // Write address phase is held over to the data phase, where hwdata stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_phase & hwrite & a_hit;
      wr_addr <= a_ofs;
    end
  end

  // Read data captured at the end of the address phase: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      if (addr_phase && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= ppi_pkg::CTRL_RESET; // Per-port switching by default
      oc_time <= {ppi_pkg::OC_TIME_RESET, ppi_pkg::OC_TIME_RESET};
      ind_ctrl <= ppi_pkg::IND_RESET; // Automatic mode at power-up
    end else begin
      if (wr_ctrl) begin
        ctrl <= hwdata[2:0];
      end
      if (wr_oct) begin
        oc_time <= hwdata[7:0];
      end
      if (wr_ind) begin
        ind_ctrl <= hwdata[15:0];
      end
    end
  end

  // Port state held by this block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_req <= 4'h0; // Ports start unpowered
      port_en <= 4'h0;
      oc_flag <= 4'h0;
      bab_flag <= 4'h0;
      ind_override <= 4'h0;
    end else begin
      power_req <= next_power_req;
      port_en <= next_port_en;
      oc_flag <= next_oc_flag;
      bab_flag <= next_bab_flag;
      // Any manual selection counts as a host override until reset
      ind_override <= ind_override | ind_manual_wr;
    end
  end

  // Millisecond tick from the core clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt <= 18'h00000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_cnt == 18'(MS_CYCLES - 1));
      ms_cnt <= (ms_cnt == 18'(MS_CYCLES - 1)) ? 18'h00000 : ms_cnt + 18'h00001;
    end
  end

  // Blink phase counted in milliseconds, so the rate follows the tick, not the clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt <= 9'h000;
      blink_phase <= 1'b0;
    end else if (ms_tick) begin
      if (blink_cnt == 9'(ppi_pkg::BLINK_HALF_MS - 1)) begin
        blink_cnt <= 9'h000;
        blink_phase <= ~blink_phase;
      end else begin
        blink_cnt <= blink_cnt + 9'h001;
      end
    end
  end

  // Switch flags are asynchronous to the core clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oc_meta <= 4'h0;
      oc_sync <= 4'h0;
    end else begin
      oc_meta <= ~port_overcurrent_flag_n; // Low means over-current
      oc_sync <= oc_meta;
    end
  end

  // Qualification: the flag must stay asserted for the programmed whole milliseconds.
  // The first tick may come right after the flag falls, so one extra tick is counted:
  // the wait lies between the limit and the limit plus one millisecond, never below.
  for (genvar p = 0; p < ppi_pkg::NPORTS; p++) begin : g_oc
    wire [3:0] limit = port_en[p] ? oc_time[ppi_pkg::OC_EN_LSB +: 4]
                                  : oc_time[ppi_pkg::OC_DIS_LSB +: 4];
    wire reached = oc_sync[p] & ((limit == 4'h0) | (oc_cnt[p] > {1'b0, limit}));
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        oc_cnt[p] <= 5'h00;
        oc_qual[p] <= 1'b0;
      end else begin
        oc_qual[p] <= reached & ~oc_qual[p] & ~oc_flag[p];
        if (!oc_sync[p]) begin
          oc_cnt[p] <= 5'h00;
        end else if (ms_tick && oc_cnt[p] != 5'h10) begin
          oc_cnt[p] <= oc_cnt[p] + 5'h01;
        end
      end
    end
  end

  // Indicator colour per port
  logic [3:0] next_green;
  logic [3:0] next_amber;
  always_comb begin
    logic [1:0] c;
    c = 2'h0;
    next_green = 4'h0;
    next_amber = 4'h0;
    for (int p = 0; p < ppi_pkg::NPORTS; p++) begin
      if (ind_ctrl[4 * p + ppi_pkg::IND_MANUAL_BIT]) begin
        c = manual_colour(ind_ctrl[4 * p +: 3], blink_phase);
      end else if (port_en[p] && !ind_override[p]) begin
        c = 2'h2; // Port reset lights green
      end else begin
        c = auto_colour(port_state[4 * p +: 4], oc_flag[p], no_switch);
      end
      next_green[p] = c[1] & ~ind_dis;
      next_amber[p] = c[0] & ~ind_dis;
    end
  end

  // Registered outputs to the switch and the LEDs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_power_enable_n <= 4'hF;
      port_led_green <= 4'h0;
      port_led_amber <= 4'h0;
      hub_characteristics <= 8'h80;
    end else begin
      port_power_enable_n <= ~power_on;
      port_led_green <= next_green;
      port_led_amber <= next_amber;
      hub_characteristics <= {~ind_dis, 7'h00};
    end
  end

  // Registered outputs to the hub controller and the upstream port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up_high_speed <= 1'b0;
      up_event_block <= 1'b0;
      port_disconnect <= 4'h0;
    end else begin
      up_high_speed <= hub_cfg_high_speed;
      // Hold off the upstream path so the parent hub never sees the event
      up_event_block <= repeater_upstream_active & (|(bab_hit | ds_disconnect));
      port_disconnect <= bab_hit;
    end
  end

  wire unused_ok = &{1'b0, hsize, haddr[1:0]};

endmodule
`default_nettype wire

// File: ppi_switch_model.sv
/* Behavioural model of the four external power switch channels.
   Assumes the bench injects faults; flags are open drain with pull-ups. */
`timescale 1ns/1ps
`default_nettype none
module ppi_switch_model (
  // Enables from the hub
  input wire logic [3:0] port_power_enable_n,
  // Fault injection
  input wire logic [3:0] fault,
  // Flags to the hub
  output logic [3:0] port_overcurrent_flag_n
);
  // A channel only flags while switched on; the pull-up holds it high otherwise
  assign port_overcurrent_flag_n = ~(fault & ~port_power_enable_n);
endmodule
`default_nettype wire

// File: ppi_monitor.sv
/* Port-level checker for the power and indicator block.
   Assumes only the top module ports; bound at the foot of the file. */
`timescale 1ns/1ps
`default_nettype none
module ppi_monitor #(
  parameter int MS_CYCLES = 10
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Hub controller side
  input wire logic hub_cfg_high_speed,
  input wire logic repeater_upstream_active,
  input wire logic [3:0] ds_babble,
  input wire logic [3:0] ds_disconnect,
  input wire logic up_high_speed,
  input wire logic up_event_block,
  input wire logic [3:0] port_disconnect,
  input wire logic [7:0] hub_characteristics,
  // Switch and LEDs
  input wire logic [3:0] port_power_enable_n,
  input wire logic [3:0] port_overcurrent_flag_n,
  input wire logic [3:0] port_led_green,
  input wire logic [3:0] port_led_amber
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Longest limit plus tick jitter and synchroniser
  localparam int OC_MAX = 16 * MS_CYCLES + 8;
  int oc_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oc_cnt <= 0;
    end else if (!port_overcurrent_flag_n[1] && !port_power_enable_n[1]) begin
      oc_cnt <= oc_cnt + 1;
    end else begin
      oc_cnt <= 0;
    end
  end
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  chk_up_speed: assert property (##1 up_high_speed == $past(hub_cfg_high_speed))
    else $error("upstream speed does not follow configuration");
  chk_block_cause: assert property (up_event_block |-> $past(repeater_upstream_active))
    else $error("event blocked while not repeating");
  chk_block_event: assert property (repeater_upstream_active && ds_disconnect != 4'h0 |=> up_event_block)
    else $error("disconnect not blocked");
  chk_disc_cause: assert property (port_disconnect != 4'h0 |-> (port_disconnect & ~$past(ds_babble)) == 4'h0)
    else $error("port dropped without babble");
  chk_disc_pulse: assert property (port_disconnect != 4'h0 |=> port_disconnect == 4'h0)
    else $error("disconnect pulse too long");
  chk_hub_char: assert property (hub_characteristics[6:0] == 7'h0)
    else $error("characteristics spare bits set");
  chk_led_excl: assert property ((port_led_green & port_led_amber) == 4'h0)
    else $error("both colours lit");
  chk_oc_drop: assert property (oc_cnt <= OC_MAX)
    else $error("power not dropped on over-current");
  chk_reset_dark: assert property ($rose(hresetn) |-> port_power_enable_n == 4'hF && (port_led_green | port_led_amber) == 4'h0)
    else $error("ports not dark after reset");
endmodule
bind ppi_port_power_indicator_ctrl ppi_monitor #(.MS_CYCLES(MS_CYCLES)) mon_u (.*);
`default_nettype wire

// File: test_port_power_indicator_ctrl.sv
/* Self-checking bench: AHB-Lite register calls and pin checks.
   Assumes the switch model on the far side and a 250 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module test_port_power_indicator_ctrl;
  localparam int MS = 10;
  localparam logic [1:0] ORX [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1, 2'h0};
  localparam logic [1:0] ANX [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic hs_cfg = 1'b0;
  logic rep = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] bab = 4'h0;
  logic [3:0] disc = 4'h0;
  logic [3:0] fault = 4'h0;
  logic [15:0] pstate = 16'h0;
  logic hreadyout;
  logic hresp;
  logic up_hs;
  logic up_blk;
  logic [31:0] hrdata;
  logic [7:0] hchar;
  logic [3:0] pen_n;
  logic [3:0] oc_n;
  logic [3:0] green;
  logic [3:0] amber;
  logic [3:0] pdisc;
  int bad_count = 0;
  int n_compared = 0;
  ppi_port_power_indicator_ctrl #(.MS_CYCLES(MS)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .hub_cfg_high_speed(hs_cfg),
    .repeater_upstream_active(rep), .ds_babble(bab), .ds_disconnect(disc),
    .port_state(pstate), .up_high_speed(up_hs), .up_event_block(up_blk),
    .port_disconnect(pdisc), .hub_characteristics(hchar), .port_power_enable_n(pen_n),
    .port_overcurrent_flag_n(oc_n), .port_led_green(green), .port_led_amber(amber));
  ppi_switch_model sw_u (.port_power_enable_n(pen_n), .fault(fault),
    .port_overcurrent_flag_n(oc_n));
  initial begin
    forever #2 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Bounded wait for hready sampled high
  task automatic wait_rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin
        bad_count++;
        test_done();
      end
      @(posedge hclk);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  initial begin
    logic [1:0] orv;
    logic [1:0] andv;
    cyc(10);
    hresetn <= 1'b1;
    cyc(1);
    chk({28'h0, pen_n}, 32'hF);
    rdc(ppi_pkg::OC_TIME_OFS, 32'h88);
    rdc(ppi_pkg::HUB_CHAR_OFS, 32'h80);
    rdc(ppi_pkg::IND_OFS, 32'h0);
    rdc(8'h40, 32'h0);
    wr(ppi_pkg::CTRL_OFS, 32'h1);
    wr(ppi_pkg::POWER_OFS, 32'h4);
    cyc(2);
    chk({28'h0, pen_n}, 32'h0);
    wr(ppi_pkg::CTRL_OFS, 32'h0);
    cyc(2);
    chk({28'h0, pen_n}, 32'hB);
    wr(ppi_pkg::POWER_OFS, 32'h6);
    fault <= 4'h2;
    cyc(6 * MS);
    chk({28'h0, pen_n}, 32'h9);
    cyc(4 * MS);
    chk({28'h0, pen_n}, 32'hB);
    fault <= 4'h0;
    rdc(ppi_pkg::STATUS_OFS, 32'h402);
    chk({28'h0, amber}, 32'h2);
    wr(ppi_pkg::OC_TIME_OFS, 32'h08);
    fault <= 4'h4;
    cyc(8);
    chk({28'h0, pen_n}, 32'hF);
    fault <= 4'h0;
    // Port 1 carries a latched fault, so amber depends on switching mode
    for (int m = 0; m < 2; m++) begin
      wr(ppi_pkg::CTRL_OFS, m ? 32'h4 : 32'h0);
      for (int s = 0; s < 13; s++) begin
        pstate <= {8'h0, s[3:0], 4'h0};
        cyc(3);
        chk({30'h0, green[1], amber[1]}, {30'h0, s inside {[6:8]},
            m ? s inside {[1:5]} : s == 0});
      end
    end
    wr(ppi_pkg::CTRL_OFS, 32'h0);
    pstate <= 16'h0;
    wr(ppi_pkg::RESET_OFS, 32'h1);
    cyc(2);
    chk({28'h0, green}, 32'h1);
    rdc(ppi_pkg::ENABLE_OFS, 32'h1);
    rep <= 1'b1;
    bab <= 4'h1;
    disc <= 4'h8;
    hs_cfg <= 1'b1;
    cyc(1);
    bab <= 4'h0;
    disc <= 4'h0;
    #1 chk({26'h0, up_hs, up_blk, pdisc}, 32'h31);
    cyc(2);
    rep <= 1'b0;
    chk({28'h0, green}, 32'h0);
    rdc(ppi_pkg::ENABLE_OFS, 32'h0);
    rdc(ppi_pkg::STATUS_OFS, 32'h016);
    // Each selector watched over a full blink period
    for (int s = 0; s < 6; s++) begin
      wr(ppi_pkg::IND_OFS, {16'h0, 1'b1, s[2:0], 12'h0});
      cyc(2);
      orv = 2'h0;
      andv = 2'h3;
      repeat (2 * ppi_pkg::BLINK_HALF_MS * MS + 100) begin
        @(posedge hclk);
        orv = orv | {green[3], amber[3]};
        andv = andv & {green[3], amber[3]};
      end
      chk({28'h0, orv, andv}, {28'h0, ORX[s], ANX[s]});
    end
    wr(ppi_pkg::IND_OFS, 32'hA000);
    wr(ppi_pkg::CTRL_OFS, 32'h2);
    cyc(2);
    chk({28'h0, green}, 32'h0);
    rdc(ppi_pkg::HUB_CHAR_OFS, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
